// ==== hw/usb_port_params.svh ====
`ifndef USB_PORT_PARAMS_SVH
`define USB_PORT_PARAMS_SVH

// Register byte address of the port status and control word
`define PSC_ADDR           32'h0000_0000
// Bit positions inside the port status and control word
`define PSC_BIT_FORCE_RES  6
`define PSC_BIT_OC_CHANGE  5
`define PSC_BIT_OC_ACTIVE  4
`define PSC_BIT_EN_CHANGE  3
`define PSC_BIT_PORT_EN    2
// Resume K drive time in microseconds and its cycle count at 200 MHz
`define RESUME_TIME_US     20000
`define CLK_MHZ            200
`define RESUME_CYCLES      (`RESUME_TIME_US * `CLK_MHZ)
// Time the port takes to settle a disable request, in cycles
`define DISABLE_LAG_CYCLES 4
// AHB transfer type and transfer size codes
`define HTRANS_NONSEQ      2'h2
`define HSIZE_WORD         3'h2
// Read value of bits outside the implemented field
`define PSC_ZERO           32'h0000_0000

`endif

// ==== hw/usb_port_pkg.sv ====
package usb_port_pkg;

  // Resume sequencer states
  typedef enum logic [1:0] {
    res_idle,
    res_drive,
    res_wait_idle
  } resume_state_type;

  // Port enable states
  typedef enum logic [1:0] {
    en_off,
    en_on,
    en_disabling
  } enable_state_type;

endpackage

// ==== hw/line_sync.sv ====
// Two-flop synchroniser for a group of pin levels
module line_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage

  // Both stages reset to zero; the first is read by nothing else
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ==== hw/resume_timer.sv ====
// Counts out the resume K drive time once started
module resume_timer #(
  parameter int CYCLES = 4000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Start pulse and completion pulse
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] count_q;  // Remaining cycles of the drive time

  // Count down; done pulses in the cycle after the last drive cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 32'h0000_0000;
      done    <= 1'b0;
    end else if (start) begin
      count_q <= 32'(CYCLES);
      done    <= 1'b0;
    end else if (count_q != 32'h0000_0000) begin
      count_q <= count_q - 32'h0000_0001;
      done    <= (count_q == 32'h0000_0001);
    end else begin
      done    <= 1'b0;
    end
  end

  assign busy = (count_q != 32'h0000_0000);

  // Assertions: a start must lead to a run of at least two cycles
  sequence s_load;
    start;
  endsequence

  sequence s_count_two;
    busy ##1 busy;
  endsequence

  property p_timer_runs;
    @(posedge clk) disable iff (!arst_n)
      s_load |=> s_count_two;
  endproperty
  a_timer_runs: assert property (p_timer_runs)
    else $error("resume timer did not run after start");

  // The last counted cycle must raise done and end the run
  property p_timer_done;
    @(posedge clk) disable iff (!arst_n)
      count_q == 32'h0000_0001 && !start |=> done && !busy;
  endproperty
  a_timer_done: assert property (p_timer_done)
    else $error("resume timer did not finish");

endmodule

// ==== hw/usb_port_resume_enable_ctrl.sv ====
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`include "usb_port_params.svh"
// Overview of operation
// - Host: software one starts resume drive
// - Host: J-to-K in suspend sets resume
// - Detected resume also sets port change
// - Host: resume bit self-clears at end
// - Host: resume bit one drives timed full-speed K
// - Host: resume bit holds until high-speed idle
// - Software zero write to resume ignored
// - Device: resume clears on normal operation
// - Over-current bits always read zero
// - Enable change set on fault disable only
// - Enable change cleared by writing one
// - Device: enable change reads zero
// - Host: only hardware sets port enable
// - Fault or software clears port enable
// - Enable bit follows actual port state
// - Disabled port blocks data except reset
// - Host power off zeroes bits; device enable one
// - Unpowered port reports no attach events
// - Enable and suspend encode port state
module usb_port_resume_enable_ctrl #(
  parameter int RESUME_CYCLES = `RESUME_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Port context from the rest of the port logic
  input  wire logic        host_role,
  input  wire logic        port_power_bit,
  input  wire logic        suspend_state_bit,
  input  wire logic        reset_enable_done,
  input  wire logic        port_in_reset,
  input  wire logic        disconnect_fault,
  input  wire logic        eof2_fault,
  input  wire logic        hs_idle_reached,
  input  wire logic        device_resumed,
  input  wire logic        connect_event_in,
  // Bus line levels from the pins: bit1 is D+, bit0 is D-
  input  wire logic [1:0]  line_pins,
  // Data path gating
  input  wire logic        tx_data_valid_in,
  output logic             tx_data_valid_out,
  // Line drive and status outputs
  output logic             drive_k,
  output logic             port_change_detect,
  output logic             connect_event_out,
  output logic [1:0]       port_state
);

  logic [1:0]  line_s;          // Synchronised line state
  logic [1:0]  line_prev_q;     // Previous synchronised line state
  logic        force_res_q;     // Force resume bit
  logic        en_change_q;     // Enable change flag
  logic        port_en_q;       // Host port enable bit
  logic        wr_pend_q;       // Write data phase pending
  logic [2:0]  lag_q;           // Disable settling counter
  logic        j_to_k;          // J to K transition this cycle
  logic        sw_resume;       // Software writes one to resume
  logic        sw_disable;      // Software writes zero to enable
  logic        sw_clr_change;   // Software clears enable change
  logic        timer_start;     // Start of a host resume drive
  logic        timer_busy;      // Resume timer running
  logic        timer_done;      // Resume timer finished
  logic        fault;           // Disconnect or EOF2 fault
  logic        res_zero;        // Resume bit forced low
  logic [31:0] read_word;       // Assembled register image
  usb_port_pkg::resume_state_type res_q;   // Resume sequencer
  usb_port_pkg::enable_state_type en_q;    // Enable sequencer

  // Pins come from outside the clock domain
  line_sync #(
    .WIDTH (2)
  ) u_line_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (line_pins),
    .dout   (line_s)
  );

  // Host drive time counter
  resume_timer #(
    .CYCLES (RESUME_CYCLES)
  ) u_resume_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (timer_start),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  // Full-speed J is D+ high, K is D- high
  function automatic logic is_j(input logic [1:0] ls);
    is_j = (ls == 2'h2);
  endfunction
  function automatic logic is_k(input logic [1:0] ls);
    is_k = (ls == 2'h1);
  endfunction

  // Track the previous line state for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_prev_q <= 2'h0;
    end else begin
      line_prev_q <= line_s;
    end
  end

  assign j_to_k = is_j(line_prev_q) && is_k(line_s) && suspend_state_bit
                  && port_power_bit;
  assign fault  = disconnect_fault || eof2_fault;
  // AHB address phase capture; data phase is zero wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite
                   && (haddr == `PSC_ADDR);
    end
  end
  assign sw_resume     = wr_pend_q && hwdata[`PSC_BIT_FORCE_RES];
  assign sw_disable    = wr_pend_q && !hwdata[`PSC_BIT_PORT_EN];
  assign sw_clr_change = wr_pend_q && hwdata[`PSC_BIT_EN_CHANGE];
  assign timer_start   = host_role && (res_q == usb_port_pkg::res_idle)
                         && (sw_resume || j_to_k);
  assign res_zero      = !port_power_bit && host_role;
  // Resume sequencer: a zero write never reaches this logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_q       <= usb_port_pkg::res_idle;
      force_res_q <= 1'b0;
    end else if (res_zero) begin
      res_q       <= usb_port_pkg::res_idle;
      force_res_q <= 1'b0;
    end else begin
      case (res_q)
        usb_port_pkg::res_idle: begin
          if (sw_resume || j_to_k) begin
            force_res_q <= 1'b1;
            res_q       <= host_role ? usb_port_pkg::res_drive
                                     : usb_port_pkg::res_wait_idle;
          end
        end
        usb_port_pkg::res_drive: begin
          // Timed K drive; the bit holds until high-speed idle
          if (timer_done) begin
            res_q <= usb_port_pkg::res_wait_idle;
          end
        end
        usb_port_pkg::res_wait_idle: begin
          if (host_role && hs_idle_reached && !timer_busy) begin
            force_res_q <= 1'b0;
            res_q       <= usb_port_pkg::res_idle;
          end else if (!host_role && device_resumed) begin
            force_res_q <= 1'b0;
            res_q       <= usb_port_pkg::res_idle;
          end
        end
        default: begin
          res_q <= usb_port_pkg::res_idle;
        end
      endcase
    end
  end

  // K drive only while the controller owns the drive window
  assign drive_k = force_res_q && host_role
                   && (res_q == usb_port_pkg::res_drive);
  // Port change detect pulses when hardware detects resume
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_change_detect <= 1'b0;
    end else begin
      port_change_detect <= j_to_k
                            && (res_q == usb_port_pkg::res_idle);
    end
  end

  // Enable sequencer; disabling settles over a few cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q      <= usb_port_pkg::en_off;
      port_en_q <= 1'b0;
      lag_q     <= 3'h0;
    end else if (!port_power_bit) begin
      en_q      <= usb_port_pkg::en_off;
      port_en_q <= 1'b0;
      lag_q     <= 3'h0;
    end else begin
      case (en_q)
        usb_port_pkg::en_off: begin
          if (reset_enable_done) begin
            en_q      <= usb_port_pkg::en_on;
            port_en_q <= 1'b1;
          end
        end
        usb_port_pkg::en_on: begin
          if (fault) begin
            en_q      <= usb_port_pkg::en_off;
            port_en_q <= 1'b0;
          end else if (sw_disable) begin
            en_q  <= usb_port_pkg::en_disabling;
            lag_q <= 3'(`DISABLE_LAG_CYCLES);
          end
        end
        usb_port_pkg::en_disabling: begin
          // Bit drops only once the port has actually stopped
          if (fault || lag_q == 3'h1) begin
            en_q      <= usb_port_pkg::en_off;
            port_en_q <= 1'b0;
            lag_q     <= 3'h0;
          end else begin
            lag_q <= lag_q - 3'h1;
          end
        end
        default: begin
          en_q <= usb_port_pkg::en_off;
        end
      endcase
    end
  end

  // Change flag: hardware set wins over software clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_change_q <= 1'b0;
    end else if (!port_power_bit || !host_role) begin
      en_change_q <= 1'b0;
    end else if (fault && port_en_q) begin
      en_change_q <= 1'b1;
    end else if (sw_clr_change) begin
      en_change_q <= 1'b0;
    end
  end

  // Register image; device role port is always enabled
  always_comb begin
    read_word = `PSC_ZERO;
    read_word[`PSC_BIT_FORCE_RES] = force_res_q;
    read_word[`PSC_BIT_OC_CHANGE] = 1'b0;
    read_word[`PSC_BIT_OC_ACTIVE] = 1'b0;
    read_word[`PSC_BIT_EN_CHANGE] = host_role && en_change_q;
    read_word[`PSC_BIT_PORT_EN]   = host_role ? port_en_q : 1'b1;
  end

  // Read data register, loaded at the address phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= `PSC_ZERO;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= (haddr == `PSC_ADDR) ? read_word : `PSC_ZERO;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Port state, data gating and attach reporting
  assign port_state = {read_word[`PSC_BIT_PORT_EN],
                       suspend_state_bit};
  assign tx_data_valid_out = tx_data_valid_in
                             && (read_word[`PSC_BIT_PORT_EN]
                                 || port_in_reset);
  assign connect_event_out = connect_event_in && port_power_bit;

  // Assertions
  property p_oc_zero;
    @(posedge clk) disable iff (!arst_n)
      hrdata[`PSC_BIT_OC_CHANGE] == 1'b0 && hrdata[`PSC_BIT_OC_ACTIVE] == 1'b0;
  endproperty
  a_oc_zero: assert property (p_oc_zero)
    else $error("over-current bit read nonzero");
  property p_sw_resume_sets;
    @(posedge clk) disable iff (!arst_n)
      sw_resume && port_power_bit && res_q == usb_port_pkg::res_idle
      |=> force_res_q;
  endproperty
  a_sw_resume_sets: assert property (p_sw_resume_sets)
    else $error("resume write did not set resume bit");
  property p_jk_sets;
    @(posedge clk) disable iff (!arst_n)
      j_to_k && res_q == usb_port_pkg::res_idle
      |=> force_res_q && port_change_detect;
  endproperty
  a_jk_sets: assert property (p_jk_sets)
    else $error("detected resume not flagged");
  property p_k_while_drive;
    @(posedge clk) disable iff (!arst_n)
      res_q == usb_port_pkg::res_drive && host_role |-> drive_k;
  endproperty
  a_k_while_drive: assert property (p_k_while_drive)
    else $error("K not driven during resume");
  property p_zero_ignored;
    @(posedge clk) disable iff (!arst_n)
      force_res_q && port_power_bit && res_q == usb_port_pkg::res_drive
      |=> force_res_q;
  endproperty
  a_zero_ignored: assert property (p_zero_ignored)
    else $error("resume bit cleared before idle");
  property p_dev_change_zero;
    @(posedge clk) disable iff (!arst_n)
      !host_role |=> !en_change_q;
  endproperty
  a_dev_change_zero: assert property (p_dev_change_zero)
    else $error("device role change flag set");
  property p_no_sw_enable;
    @(posedge clk) disable iff (!arst_n)
      !port_en_q && !reset_enable_done |=> !port_en_q;
  endproperty
  a_no_sw_enable: assert property (p_no_sw_enable)
    else $error("port enabled without reset sequence");
  property p_fault_disables;
    @(posedge clk) disable iff (!arst_n)
      port_en_q && fault && port_power_bit && host_role
      |=> !port_en_q && en_change_q;
  endproperty
  a_fault_disables: assert property (p_fault_disables)
    else $error("fault did not disable port");
  property p_power_off;
    @(posedge clk) disable iff (!arst_n)
      !port_power_bit && host_role |=> !force_res_q && !port_en_q;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("bits not zero with power off");

endmodule

// ==== verif/usb_far_end.sv ====
// Far side of the port: a full-speed device or host that can signal
// resume by driving K for a short time, then releases the line
module usb_far_end #(
  parameter int K_LEN = 8
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Command from the bench
  input  wire logic       send_k,
  // Line drive
  output logic            oe,
  output logic      [1:0] lvl
);
  int cnt_q;  // Cycles of K still to drive

  // K level only while driving; the pull-up gives J when released
  assign lvl = 2'b01;
  assign oe  = (cnt_q != 0);

  // Resume burst timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
    end else if (send_k) begin
      cnt_q <= K_LEN;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

// ==== verif/usb_port_resume_enable_ctrl_tb.sv ====
`include "usb_port_params.svh"
module usb_port_resume_enable_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short resume time keeps the run brief
  localparam int RES_CYC = 20;
  localparam logic [31:0] PA = `PSC_ADDR;
  localparam logic [31:0] NOMAP = 32'h0000_0010;
  logic        clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, line_pins, port_state, far_lvl;
  logic [2:0]  hsize;
  logic        host_role, port_power_bit, suspend_state_bit;
  logic        reset_enable_done, port_in_reset, disconnect_fault;
  logic        eof2_fault, hs_idle_reached, device_resumed;
  logic        connect_event_in, connect_event_out, send_k, far_oe;
  logic        tx_data_valid_in, tx_data_valid_out, drive_k;
  logic        port_change_detect;
  int          mismatches = 0;
  int          checks_done = 0;
  int          pcd_cnt = 0;
  int          pc0;

  // Wire level: controller K wins, then far end, else pull-up J
  assign line_pins = drive_k ? 2'b01 : (far_oe ? far_lvl : 2'b10);

  usb_port_resume_enable_ctrl #(.RESUME_CYCLES(RES_CYC)) dut (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .host_role(host_role),
    .port_power_bit(port_power_bit),
    .suspend_state_bit(suspend_state_bit),
    .reset_enable_done(reset_enable_done),
    .port_in_reset(port_in_reset), .disconnect_fault(disconnect_fault),
    .eof2_fault(eof2_fault), .hs_idle_reached(hs_idle_reached),
    .device_resumed(device_resumed),
    .connect_event_in(connect_event_in), .line_pins(line_pins),
    .tx_data_valid_in(tx_data_valid_in),
    .tx_data_valid_out(tx_data_valid_out), .drive_k(drive_k),
    .port_change_detect(port_change_detect),
    .connect_event_out(connect_event_out), .port_state(port_state));

  usb_far_end far (.clk(clk), .arst_n(arst_n), .send_k(send_k),
                   .oe(far_oe), .lvl(far_lvl));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Change-detect is a one-cycle pulse, so count every one
  always @(posedge clk) begin
    if (port_change_detect === 1'b1) begin
      pcd_cnt <= pcd_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for ready sampled high at a rising edge
  task automatic wait_rdy;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) begin
        return;
      end
    end
    mismatches++;
    final_report;
  endtask

  // Single AHB-Lite word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, wd,
                     output logic [31:0] rdat);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= `HSIZE_WORD;
    // Address phase stands until the edge that sees ready high
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    // Data phase stands until ready again; read data taken there
    wait_rdy;
    rdat = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    // Later checks then look at settled outputs
    @(negedge clk);
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask

  // Bounded wait for the K drive to reach a level
  task automatic wait_k(input logic lvl, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (drive_k === lvl) begin
        return;
      end
    end
    mismatches++;
    final_report;
  endtask

  // One-cycle pulse on a control input, by index
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: reset_enable_done <= 1'b1;
      1: disconnect_fault <= 1'b1;
      2: eof2_fault <= 1'b1;
      3: device_resumed <= 1'b1;
      4: send_k <= 1'b1;
      default: connect_event_in <= 1'b1;
    endcase
    @(posedge clk);
    {reset_enable_done, disconnect_fault, eof2_fault} <= 3'b000;
    {device_resumed, send_k, connect_event_in} <= 3'b000;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = `HSIZE_WORD;
    {host_role, port_power_bit, tx_data_valid_in} = 3'b111;
    {suspend_state_bit, reset_enable_done, port_in_reset} = 3'b000;
    {disconnect_fault, eof2_fault, hs_idle_reached} = 3'b000;
    {device_resumed, connect_event_in, send_k} = 3'b000;
    arst_n = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(PA, v);
    chk("psc_reset", v, 32'h0);
    chk("state_off", {30'h0, port_state}, 32'h0);
    chk("tx_off", {31'h0, tx_data_valid_out}, 32'h0);
    @(posedge clk);
    port_in_reset <= 1'b1;
    @(negedge clk);
    chk("tx_rst", {31'h0, tx_data_valid_out}, 32'h1);
    @(posedge clk);
    port_in_reset <= 1'b0;
    // Software cannot enable; the reset-and-enable pulse does
    wr(PA, 32'h0000_0004);
    rd(PA, v);
    chk("en_sw", v, 32'h0);
    pulse(0);
    rd(PA, v);
    chk("en_hw", v, 32'h0000_0004);
    chk("state_on", {30'h0, port_state}, 32'h2);
    chk("tx_on", {31'h0, tx_data_valid_out}, 32'h1);
    // Remote wake from suspend, seen as J to K on the line
    @(posedge clk);
    suspend_state_bit <= 1'b1;
    @(negedge clk);
    chk("state_suspend_state_bit", {30'h0, port_state}, 32'h3);
    pc0 = pcd_cnt;
    pulse(4);
    wait_k(1'b1, 40);
    chk("pcd", 32'(pcd_cnt - pc0), 32'h1);
    wait_k(1'b0, RES_CYC + 40);
    rd(PA, v);
    chk("res_hold", v, 32'h0000_0044);
    wr(PA, 32'h0000_0004);
    rd(PA, v);
    chk("res_w0", v, 32'h44);
    @(posedge clk);
    {suspend_state_bit, hs_idle_reached} <= 2'b01;
    rd(PA, v);
    chk("res_done", v, 32'h0000_0004);
    @(posedge clk);
    hs_idle_reached <= 1'b0;
    // Software-driven resume
    wr(PA, 32'h0000_0044);
    wait_k(1'b1, 20);
    wait_k(1'b0, RES_CYC + 40);
    @(posedge clk);
    hs_idle_reached <= 1'b1;
    rd(PA, v);
    chk("sw_res_done", v, 32'h0000_0004);
    @(posedge clk);
    hs_idle_reached <= 1'b0;
    // Software disable: bit still one while the port settles
    wr(PA, 32'h0);
    rd(PA, v);
    chk("dis_lag", v, 32'h0000_0004);
    repeat (8) @(posedge clk);
    rd(PA, v);
    chk("sw_dis", v, 32'h0);
    chk("tx_dis", {31'h0, tx_data_valid_out}, 32'h0);
    // Both fault kinds disable and raise the change flag
    for (int f = 1; f <= 2; f++) begin
      pulse(0);
      pulse(f);
      rd(PA, v);
      chk("fault", v, 32'h0000_0008);
      wr(PA, 32'h0);
      rd(PA, v);
      chk("chg_w0", v, 32'h8);
      wr(PA, 32'h8);
      rd(PA, v);
      chk("chg_w1", v, 32'h0);
    end
    // Unmapped addresses read zero and ignore writes
    wr(NOMAP, 32'hffff_ffff);
    rd(NOMAP, v);
    chk("nomap", v, 32'h0);
    rd(PA, v);
    chk("nomap_w", v, 32'h0);
    // Power off hides the field and connect events
    pulse(0);
    pulse(1);
    @(posedge clk);
    port_power_bit <= 1'b0;
    rd(PA, v);
    chk("pwr_off", v, 32'h0);
    @(posedge clk);
    connect_event_in <= 1'b1;
    @(negedge clk);
    chk("conn_off", {31'h0, connect_event_out}, 32'h0);
    @(posedge clk);
    port_power_bit <= 1'b1;
    @(negedge clk);
    chk("conn_on", {31'h0, connect_event_out}, 32'h1);
    @(posedge clk);
    connect_event_in <= 1'b0;
    wr(PA, 32'h8);
    // Device role: always enabled, never a change flag
    @(posedge clk);
    {host_role, port_power_bit} <= 2'b00;
    rd(PA, v);
    chk("dev_pwr_off", v, 32'h0000_0004);
    @(posedge clk);
    {port_power_bit, suspend_state_bit} <= 2'b11;
    pc0 = pcd_cnt;
    pulse(4);
    repeat (10) @(posedge clk);
    rd(PA, v);
    chk("dev_wake", v, 32'h0000_0044);
    chk("dev_pcd", 32'(pcd_cnt - pc0), 32'h1);
    pulse(3);
    rd(PA, v);
    chk("dev_resumed", v, 32'h4);
    // Software asks for resume after a 50-cycle pause
    repeat (50) @(posedge clk);
    wr(PA, 32'h0000_0044);
    rd(PA, v);
    chk("dev_sw_res", v, 32'h44);
    pulse(3);
    rd(PA, v);
    chk("dev_sw_done", v, 32'h4);
    final_report;
  end
endmodule
